// ===== common/spx_pkg.sv
package spx_pkg;

	// ==========================================================
	// bus and word widths
	localparam int SPX_ADDR_W = 8;
	localparam int SPX_DATA_W = 8;
	localparam int SPX_WORD_W = 32;
	localparam int SPX_LEN_W  = 6;

	// ==========================================================
	// register offsets
	localparam logic [7:0] SPX_ADDR_PIN_ROUTE = 8'h9d;
	localparam logic [7:0] SPX_ADDR_DATA0     = 8'he1;
	localparam logic [7:0] SPX_ADDR_DATA1     = 8'he2;
	localparam logic [7:0] SPX_ADDR_DATA2     = 8'he3;
	localparam logic [7:0] SPX_ADDR_DATA3     = 8'he4;
	localparam logic [7:0] SPX_ADDR_CTRL1     = 8'he5;
	localparam logic [7:0] SPX_ADDR_CTRL2     = 8'he6;
	localparam logic [7:0] SPX_ADDR_LEN       = 8'he7;
	localparam logic [7:0] SPX_ADDR_STATUS    = 8'he9;

	// ==========================================================
	// clock, role and select control fields
	localparam int SPX_DIV_MSB   = 7;
	localparam int SPX_DIV_LSB   = 5;
	localparam int SPX_CSEL_MSB  = 4;
	localparam int SPX_CSEL_LSB  = 3;
	localparam int SPX_PHASE_BIT = 2;
	localparam int SPX_POL_BIT   = 1;
	localparam int SPX_ROLE_BIT  = 0;

	// ==========================================================
	// select and interrupt control fields
	localparam int SPX_HOLD_BIT   = 7;
	localparam int SPX_TXCLR_BIT  = 6;
	localparam int SPX_FRAME_BIT  = 5;
	localparam int SPX_LDOPT_BIT  = 4;
	localparam int SPX_OV_BIT     = 2;
	localparam int SPX_AV_BIT     = 1;
	localparam int SPX_TE_BIT     = 0;
	localparam logic [7:0] SPX_CTRL2_WMASK = 8'hb7;

	// ==========================================================
	// length field and pin route enables
	localparam int SPX_LEN_MSB   = 4;
	localparam int SPX_PIN_SDI   = 7;
	localparam int SPX_PIN_SDO   = 6;
	localparam int SPX_PIN_SCK   = 5;
	localparam int SPX_PIN_SS    = 4;
	localparam int SPX_PIN_SEL0  = 3;

	// ==========================================================
	// reset values
	localparam logic [7:0] SPX_ROUTE_RST = 8'h00;
	localparam logic [7:0] SPX_CTRL1_RST = 8'h00;
	localparam logic [7:0] SPX_CTRL2_RST = 8'h00;
	localparam logic [4:0] SPX_LEN_RST   = 5'h07;
	localparam logic       SPX_TE_RST    = 1'b1;

	// ==========================================================
	// engine states
	typedef enum logic [1:0] {
		SPX_IDLE  = 2'b00,
		SPX_SETUP = 2'b01,
		SPX_SHIFT = 2'b10,
		SPX_LOAD  = 2'b11
	} spx_state_type;

endpackage

// ===== common/spx_shift_if.sv
`timescale 1ns/10ps
interface spx_shift_if;
	logic        load;
	logic [31:0] load_word;
	logic [5:0]  load_len;
	logic        sample;
	logic        sample_bit;
	logic        launch;
	logic        tx_bit;
	logic [31:0] rx_word;
	logic        full;

	modport ctrl (
		output load, load_word, load_len, sample, sample_bit, launch,
		input  tx_bit, rx_word, full
	);
	modport shifter (
		input  load, load_word, load_len, sample, sample_bit, launch,
		output tx_bit, rx_word, full
	);
endinterface

// ===== core/spx_port.sv
`timescale 1ns/10ps
// Behaviour
// (R01) transfers of one to thirty-two bits
// (R02) send and receive on every clock
// (R03) separate transmit and receive holding buffers
// (R04) data word spread over four byte registers
// (R05) serial clock divided from oscillator by code
// (R06) master asserts only the chosen select
// (R07) four select outputs in master mode
// (R08) role bit zero master, one slave
// (R09) polarity sets idle level, phase bit
// (R10) clock toggles only after select low
// (R11) mode 0 drive rising, sample falling
// (R12) mode 1 drive falling, sample rising
// (R13) mode 2 drive falling, sample rising
// (R14) mode 3 drive rising, sample falling
// (R15) hold bit keeps select low after end
// (R16) bit six reads zero, write clears empty
// (R17) frame select and load options on line3
// (R18) interrupt per flag only when enabled
// (R19) status holds overrun, available, empty
// (R20) rate independent of system clock control
// (R21) pin enables route data and clock pins
// (R22) pin enables route four select outputs
// (R23) overrun when unread word is replaced
// (R24) empty set when buffer enters shifter
module spx_port (
	// clock and reset
	input  wire logic                            sys_clk,
	input  wire logic                            reset,
	// special function register port
	input  wire logic [spx_pkg::SPX_ADDR_W-1:0]  sfr_addr,
	input  wire logic                            sfr_wr,
	input  wire logic                            sfr_rd,
	input  wire logic [spx_pkg::SPX_DATA_W-1:0]  sfr_wdata,
	output logic      [spx_pkg::SPX_DATA_W-1:0]  sfr_rdata,
	output logic                                 spi_irq,
	// serial pins
	input  wire logic                            sdi_i,
	input  wire logic                            ss_n_i,
	input  wire logic                            sck_i,
	output logic                                 sck_o,
	output logic                                 sck_oe,
	output logic                                 sdo_o,
	output logic                                 sdo_oe,
	// master select pins, select_out3_n is bit 3
	output logic      [3:0]                      sel_n_o,
	output logic      [3:0]                      sel_oe
);
	import spx_pkg::*;

	// ==========================================================
	// declarations
	logic [7:0]    route_q;
	logic [7:0]    route_d;
	logic [7:0]    ctrl1_q;
	logic [7:0]    ctrl1_d;
	logic [7:0]    ctrl2_q;
	logic [7:0]    ctrl2_d;
	logic [4:0]    len_q;
	logic [4:0]    len_d;
	logic [31:0]   tx_buf_q;
	logic [31:0]   tx_buf_d;
	logic [31:0]   rx_buf_q;
	logic [31:0]   rx_buf_d;
	logic          tx_full_q;
	logic          tx_full_d;
	logic          ov_q;
	logic          ov_d;
	logic          av_q;
	logic          av_d;
	logic          te_q;
	logic          te_d;
	logic [7:0]    rdata_q;
	logic [7:0]    rdata_d;
	logic          irq_q;
	logic          irq_d;

	spx_state_type state_q;
	spx_state_type state_d;
	logic [5:0]    div_cnt_q;
	logic [5:0]    div_cnt_d;
	logic [5:0]    edge_cnt_q;
	logic [5:0]    edge_cnt_d;
	logic          sck_q;
	logic          sck_d;
	logic [3:0]    sel_n_q;
	logic [3:0]    sel_n_d;
	logic          done_q;
	logic          done_d;
	logic          sdo_q;
	logic          sdo_oe_q;
	logic          sck_oe_q;
	logic [3:0]    sel_oe_q;

	logic [2:0]    sync1_q;
	logic [2:0]    sync2_q;
	logic          sck_prev_q;

	logic          master;
	logic          hold;
	logic [1:0]    csel;
	logic [3:0]    sel_one_n;
	logic          slave_sel;
	logic          half_tick;
	logic          take_c;
	logic          edge_c;
	logic          rise_c;
	logic          sample_rise;

	spx_shift_if   sh ();

	spx_shifter u_shifter (
		.sys_clk (sys_clk),
		.reset   (reset),
		.sh      (sh.shifter)
	);

	// ==========================================================
	// divider limit per clock code
	// (R05) half period in oscillator cycles, minus one
	function automatic logic [5:0] spx_half_limit(input logic [2:0] code);
		logic [5:0] lim;
		case (code)
			3'h0: lim = 6'd0;
			3'h1: lim = 6'd1;
			3'h2: lim = 6'd3;
			3'h3: lim = 6'd7;
			3'h4: lim = 6'd15;
			// unused codes fall back to the slowest rate
			default: lim = 6'd31;
		endcase
		return lim;
	endfunction

	// ==========================================================
	// decoded controls
	// (R08) role bit picks master or slave
	assign master      = ~ctrl1_q[SPX_ROLE_BIT];
	assign hold        = ctrl2_q[SPX_HOLD_BIT];
	assign csel        = ctrl1_q[SPX_CSEL_MSB:SPX_CSEL_LSB];
	// (R06) one-hot low select for the chosen line
	assign sel_one_n   = ~(4'h1 << csel);
	// (R21) select input only when routed
	assign slave_sel   = route_q[SPX_PIN_SS] & ~sync2_q[1];
	// (R11) (R12) (R13) (R14) sampling edge per mode
	assign sample_rise = ctrl1_q[SPX_POL_BIT] ^ ctrl1_q[SPX_PHASE_BIT];
	// (R20) timed only by sys_clk and own divider
	assign half_tick   =
		(div_cnt_q == spx_half_limit(ctrl1_q[SPX_DIV_MSB:SPX_DIV_LSB]));

	assign sh.load_word  = tx_buf_q;
	assign sh.load_len   = {1'b0, len_q} + 6'd1;
	// (R21) data in only when routed
	assign sh.sample_bit = route_q[SPX_PIN_SDI] & sync2_q[2];
	assign sh.sample     = edge_c & (rise_c == sample_rise);
	assign sh.launch     = edge_c & (rise_c != sample_rise);

	// ==========================================================
	// transfer engine
	always_comb begin
		state_d    = state_q;
		div_cnt_d  = div_cnt_q;
		edge_cnt_d = edge_cnt_q;
		sck_d      = sck_q;
		sel_n_d    = sel_n_q;
		done_d     = 1'b0;
		take_c     = 1'b0;
		sh.load    = 1'b0;
		edge_c     = 1'b0;
		rise_c     = 1'b0;
		if (state_q != SPX_IDLE) begin
			div_cnt_d = half_tick ? 6'd0 : div_cnt_q + 6'd1;
		end
		case (state_q)
			SPX_IDLE: begin
				div_cnt_d  = '0;
				edge_cnt_d = '0;
				// (R09) idle level follows polarity
				sck_d      = ctrl1_q[SPX_POL_BIT];
				if (master) begin
					// one idle cycle after each word, select high in it unless hold is set
					if (tx_full_q && !done_q) begin
						state_d = SPX_SETUP;
						take_c  = 1'b1;
						sh.load = 1'b1;
						// (R06) (R07) chosen line goes low first
						sel_n_d = sel_one_n;
						// (R17) frame marker on line 3
						if (ctrl2_q[SPX_FRAME_BIT]) begin
							sel_n_d[3] = 1'b0;
						end
					end else if (!hold) begin
						// (R15) release after the end or hold clear
						sel_n_d = 4'hf;
					end
				end else begin
					sel_n_d = 4'hf;
					if (slave_sel) begin
						state_d = SPX_SHIFT;
						take_c  = tx_full_q;
						sh.load = 1'b1;
					end
				end
			end
			SPX_SETUP: begin
				// (R10) select low a full period before the first sck edge
				if (half_tick) begin
					state_d = SPX_SHIFT;
					sel_n_d = sel_one_n;
				end
			end
			SPX_SHIFT: begin
				if (master) begin
					if (half_tick) begin
						edge_c     = 1'b1;
						rise_c     = ~sck_q;
						sck_d      = ~sck_q;
						edge_cnt_d = edge_cnt_q + 6'd1;
						// (R01) two edges per bit, then stop
						if (edge_cnt_q == {len_q, 1'b1}) begin
							done_d  = 1'b1;
							// select outlives the last edge, idle frees it
							state_d = SPX_IDLE;
							// (R17) load strobe on line 3
							if (ctrl2_q[SPX_LDOPT_BIT]) begin
								state_d    = SPX_LOAD;
								// (R15) automatic release unless held
								if (!hold) begin
									sel_n_d = 4'hf;
								end
								sel_n_d[3] = 1'b0;
							end
						end
					end
				end else begin
					// (R21) clock input only when routed
					edge_c = route_q[SPX_PIN_SCK]
						& (sync2_q[0] != sck_prev_q);
					rise_c = sync2_q[0];
					if (!slave_sel) begin
						// aborted word is dropped, not reported
						state_d = SPX_IDLE;
					end else if (sh.full) begin
						done_d  = 1'b1;
						state_d = SPX_IDLE;
					end
				end
			end
			SPX_LOAD: begin
				if (half_tick) begin
					state_d = SPX_IDLE;
					sel_n_d = hold ? sel_one_n : 4'hf;
				end
			end
			default: begin
				state_d = SPX_IDLE;
			end
		endcase
		if (state_q != SPX_IDLE && !master && state_q != SPX_SHIFT) begin
			state_d = SPX_IDLE;
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			state_q    <= SPX_IDLE;
			div_cnt_q  <= '0;
			edge_cnt_q <= '0;
			sck_q      <= 1'b0;
			sel_n_q    <= 4'hf;
			done_q     <= 1'b0;
		end else begin
			state_q    <= state_d;
			div_cnt_q  <= div_cnt_d;
			edge_cnt_q <= edge_cnt_d;
			sck_q      <= sck_d;
			sel_n_q    <= sel_n_d;
			done_q     <= done_d;
		end
	end

	// ==========================================================
	// pin synchronisers and pin drivers
	// master sampling sees sdi two cycles late; codes 2 and up
	// leave margin, divide by 2 and by 4 may not
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			sync1_q    <= 3'h7;
			sync2_q    <= 3'h7;
			// matches the synchroniser so no false edge
			sck_prev_q <= 1'b1;
			sdo_q      <= 1'b0;
			sdo_oe_q   <= 1'b0;
			sck_oe_q   <= 1'b0;
			sel_oe_q   <= 4'h0;
		end else begin
			sync1_q    <= {sdi_i, ss_n_i, sck_i};
			sync2_q    <= sync1_q;
			sck_prev_q <= sync2_q[0];
			sdo_q      <= sh.tx_bit;
			// (R21) data out and clock only when routed
			sdo_oe_q   <= route_q[SPX_PIN_SDO] & (master | slave_sel);
			sck_oe_q   <= route_q[SPX_PIN_SCK] & master;
			// (R22) select outputs, bit 3 for line 0
			sel_oe_q   <= {route_q[SPX_PIN_SEL0-3], route_q[SPX_PIN_SEL0-2],
				route_q[SPX_PIN_SEL0-1], route_q[SPX_PIN_SEL0]}
				& {4{master}};
		end
	end

	// ==========================================================
	// register file
	always_comb begin
		route_d   = route_q;
		ctrl1_d   = ctrl1_q;
		ctrl2_d   = ctrl2_q;
		len_d     = len_q;
		tx_buf_d  = tx_buf_q;
		rx_buf_d  = rx_buf_q;
		tx_full_d = tx_full_q;
		ov_d      = ov_q;
		av_d      = av_q;
		te_d      = te_q;
		rdata_d   = rdata_q;
		if (sfr_wr) begin
			if (sfr_addr == SPX_ADDR_PIN_ROUTE) begin
				route_d = sfr_wdata;
			end else if (sfr_addr == SPX_ADDR_DATA0) begin
				// (R03) (R04) low byte commits the word
				tx_buf_d[7:0] = sfr_wdata;
				tx_full_d     = 1'b1;
				te_d          = 1'b0;
			end else if (sfr_addr == SPX_ADDR_DATA1) begin
				tx_buf_d[15:8] = sfr_wdata;
			end else if (sfr_addr == SPX_ADDR_DATA2) begin
				tx_buf_d[23:16] = sfr_wdata;
			end else if (sfr_addr == SPX_ADDR_DATA3) begin
				tx_buf_d[31:24] = sfr_wdata;
			end else if (sfr_addr == SPX_ADDR_CTRL1) begin
				ctrl1_d = sfr_wdata;
			end else if (sfr_addr == SPX_ADDR_CTRL2) begin
				// (R16) clear bit is never stored
				ctrl2_d = sfr_wdata & SPX_CTRL2_WMASK;
				if (sfr_wdata[SPX_TXCLR_BIT]) begin
					te_d = 1'b0;
				end
			end else if (sfr_addr == SPX_ADDR_LEN) begin
				len_d = sfr_wdata[SPX_LEN_MSB:0];
			end
		end
		if (sfr_rd) begin
			rdata_d = 8'h00;
			if (sfr_addr == SPX_ADDR_PIN_ROUTE) begin
				rdata_d = route_q;
			end else if (sfr_addr == SPX_ADDR_DATA0) begin
				// (R04) byte 0 read also drains the buffer
				rdata_d = rx_buf_q[7:0];
				av_d    = 1'b0;
			end else if (sfr_addr == SPX_ADDR_DATA1) begin
				rdata_d = rx_buf_q[15:8];
			end else if (sfr_addr == SPX_ADDR_DATA2) begin
				rdata_d = rx_buf_q[23:16];
			end else if (sfr_addr == SPX_ADDR_DATA3) begin
				rdata_d = rx_buf_q[31:24];
			end else if (sfr_addr == SPX_ADDR_CTRL1) begin
				rdata_d = ctrl1_q;
			end else if (sfr_addr == SPX_ADDR_CTRL2) begin
				rdata_d = ctrl2_q;
			end else if (sfr_addr == SPX_ADDR_LEN) begin
				rdata_d = {3'h0, len_q};
			end else if (sfr_addr == SPX_ADDR_STATUS) begin
				// (R19) overrun, available, empty
				rdata_d = {5'h00, ov_q, av_q, te_q};
				ov_d    = 1'b0;
			end
		end
		// hardware sets come last so they win over clears
		if (take_c) begin
			// (R24) buffer moved into the shifter
			// a commit in the take cycle stays queued
			tx_full_d = sfr_wr && (sfr_addr == SPX_ADDR_DATA0);
			te_d      = 1'b1;
		end
		if (done_q) begin
			// (R03) received word parked for software
			rx_buf_d = sh.rx_word;
			av_d     = 1'b1;
			// (R23) previous word still unread
			if (av_q) begin
				ov_d = 1'b1;
			end
		end
		// (R18) each flag gated by its own enable
		irq_d = |({ov_q, av_q, te_q} & ctrl2_q[SPX_OV_BIT:SPX_TE_BIT]);
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			route_q   <= SPX_ROUTE_RST;
			ctrl1_q   <= SPX_CTRL1_RST;
			ctrl2_q   <= SPX_CTRL2_RST;
			len_q     <= SPX_LEN_RST;
			tx_buf_q  <= '0;
			rx_buf_q  <= '0;
			tx_full_q <= 1'b0;
			ov_q      <= 1'b0;
			av_q      <= 1'b0;
			te_q      <= SPX_TE_RST;
			rdata_q   <= 8'h00;
			irq_q     <= 1'b0;
		end else begin
			route_q   <= route_d;
			ctrl1_q   <= ctrl1_d;
			ctrl2_q   <= ctrl2_d;
			len_q     <= len_d;
			tx_buf_q  <= tx_buf_d;
			rx_buf_q  <= rx_buf_d;
			tx_full_q <= tx_full_d;
			ov_q      <= ov_d;
			av_q      <= av_d;
			te_q      <= te_d;
			rdata_q   <= rdata_d;
			irq_q     <= irq_d;
		end
	end

	// ==========================================================
	// outputs
	assign sfr_rdata = rdata_q;
	assign spi_irq   = irq_q;
	assign sck_o     = sck_q;
	assign sck_oe    = sck_oe_q;
	assign sdo_o     = sdo_q;
	assign sdo_oe    = sdo_oe_q;
	assign sel_n_o   = sel_n_q;
	assign sel_oe    = sel_oe_q;

endmodule

// ===== core/spx_shifter.sv
`timescale 1ns/10ps
module spx_shifter (
	// clock and reset
	input wire logic     sys_clk,
	input wire logic     reset,
	// control side
	spx_shift_if.shifter sh
);
	import spx_pkg::*;

	logic [31:0] tx_q;
	logic [31:0] tx_d;
	logic [31:0] rx_q;
	logic [31:0] rx_d;
	logic [5:0]  cnt_q;
	logic [5:0]  cnt_d;
	logic [5:0]  len_q;
	logic [5:0]  len_d;
	logic        pend_q;
	logic        pend_d;
	logic [5:0]  pad;

	// ==========================================================
	// shift register next state
	always_comb begin
		tx_d   = tx_q;
		rx_d   = rx_q;
		cnt_d  = cnt_q;
		len_d  = len_q;
		pend_d = pend_q;
		pad    = 6'd32 - sh.load_len;
		if (sh.load) begin
			// (R01) msb of word first
			tx_d   = sh.load_word << pad;
			rx_d   = '0;
			cnt_d  = '0;
			len_d  = sh.load_len;
			pend_d = 1'b0;
		end else begin
			// (R02) in and out per clock
			if (sh.sample) begin
				rx_d   = {rx_q[30:0], sh.sample_bit};
				cnt_d  = cnt_q + 6'd1;
				pend_d = 1'b1;
			end
			// first launch before any sample keeps the preset bit
			if (sh.launch && pend_q) begin
				tx_d   = {tx_q[30:0], 1'b0};
				pend_d = 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			tx_q   <= '0;
			rx_q   <= '0;
			cnt_q  <= '0;
			len_q  <= 6'd1;
			pend_q <= 1'b0;
		end else begin
			tx_q   <= tx_d;
			rx_q   <= rx_d;
			cnt_q  <= cnt_d;
			len_q  <= len_d;
			pend_q <= pend_d;
		end
	end

	assign sh.tx_bit  = tx_q[31];
	assign sh.rx_word = rx_q;
	// (R01) complete after exactly len samples
	assign sh.full    = (cnt_q == len_q);

endmodule

// ===== tb/spx_port_assertions.sv
`timescale 1ns/10ps
// ==========================================================
// port checker
module spx_port_checker
	import spx_pkg::*;
(
	// clock and reset
	input wire logic       sys_clk,
	input wire logic       reset,
	// register port
	input wire logic [7:0] sfr_addr,
	input wire logic       sfr_wr,
	input wire logic       sfr_rd,
	input wire logic [7:0] sfr_wdata,
	input wire logic [7:0] sfr_rdata,
	input wire logic       spi_irq,
	// serial pins
	input wire logic       sck_o,
	input wire logic       sck_oe,
	input wire logic [3:0] sel_n_o,
	input wire logic [3:0] sel_oe
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);

	a_sel_single: assert property ($onehot0(~sel_n_o[2:0]))
		else $error("more than one select low");
	// writes may move the idle level, so they are masked out
	a_sck_needs_sel: assert property (
		sck_oe && $past(sck_oe) && $changed(sck_o) && !$past(sfr_wr)
		&& !$past(sfr_wr, 2) && !$past(sfr_wr, 3) |-> !(&sel_n_o))
		else $error("serial clock moved with no select low");
	a_rdata_hold: assert property (
		!$past(sfr_rd) |-> $stable(sfr_rdata))
		else $error("read data moved without a read");
	a_ctrl2_zero: assert property (
		sfr_rd && sfr_addr == SPX_ADDR_CTRL2
		|=> !sfr_rdata[SPX_TXCLR_BIT] && !sfr_rdata[3])
		else $error("clear bit read back as one");
	a_status_top: assert property (
		sfr_rd && sfr_addr == SPX_ADDR_STATUS |=> sfr_rdata[7:3] == 5'h00)
		else $error("status upper bits not zero");
	a_ov_cleared: assert property (
		$past(&sel_n_o, 2) && sfr_rd && sfr_addr == SPX_ADDR_STATUS
		##2 sfr_rd && sfr_addr == SPX_ADDR_STATUS |=> !sfr_rdata[SPX_OV_BIT])
		else $error("overrun survived a status read");
	a_irq_off: assert property (
		sfr_wr && sfr_addr == SPX_ADDR_CTRL2 && sfr_wdata[2:0] == 3'h0
		|-> ##2 !spi_irq)
		else $error("interrupt with all enables clear");
	a_oe_by_write: assert property (
		$changed({sck_oe, sel_oe}) |-> $past(sfr_wr) || $past(sfr_wr, 2))
		else $error("pin enable moved without a write");

	c_sel3: cover property ($fell(sel_n_o[3]));
	c_irq: cover property ($rose(spi_irq));
	c_ov: cover property (sfr_rd && sfr_addr == SPX_ADDR_STATUS
		##1 sfr_rdata[SPX_OV_BIT]);
endmodule

bind spx_port spx_port_checker u_spx_port_checker (
	.sys_clk(sys_clk), .reset(reset), .sfr_addr(sfr_addr),
	.sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
	.sfr_rdata(sfr_rdata), .spi_irq(spi_irq), .sck_o(sck_o),
	.sck_oe(sck_oe), .sel_n_o(sel_n_o), .sel_oe(sel_oe));

// ===== tb/spx_slave_model.sv
`timescale 1ns/10ps
// ==========================================================
// serial slave stand-in
module spx_slave_model (
	// serial lines
	input  wire logic        sck,
	input  wire logic        sel_n,
	input  wire logic        sdo,
	output logic             sdi,
	// setup from the bench
	input  wire logic [1:0]  mode,
	input  wire logic [5:0]  len,
	input  wire logic [31:0] tx,
	output logic [31:0]      rx
);
	logic d;
	int   cnt;

	initial begin
		d = 1'b0;
		rx = 32'h0000_0000;
		cnt = 0;
	end
	always @(negedge sel_n) begin
		cnt = 0;
		rx = 32'h0000_0000;
		d = tx[len-1];
	end
	always @(sck) begin
		if (!sel_n) begin
			if (sck == (mode[1] ^ mode[0])) begin
				rx = {rx[30:0], sdo};
				cnt++;
			end else if (cnt > 0 && cnt < len) begin
				d = tx[len-1-cnt];
			end
		end
	end
	// released line flips so stale bits cannot pass
	assign sdi = sel_n ? ~d : d;
endmodule

// ===== tb/tb_spi_master_slave_port.sv
`timescale 1ns/10ps
// ==========================================================
// bench for the serial port
module tb_spi_master_slave_port;
	import spx_pkg::*;
	logic        sys_clk = 1'b0;
	logic        reset = 1'b1;
	logic [7:0]  sfr_addr = 8'h00;
	logic        sfr_wr = 1'b0;
	logic        sfr_rd = 1'b0;
	logic [7:0]  sfr_wdata = 8'h00;
	logic [7:0]  sfr_rdata;
	logic        spi_irq;
	logic        sdi;
	logic        sck_o;
	logic        sck_oe;
	logic        sdo_o;
	logic        sdo_oe;
	logic [3:0]  sel_n_o;
	logic [3:0]  sel_oe;
	logic [1:0]  m_mode = 2'h0;
	logic [1:0]  line = 2'h0;
	logic [5:0]  m_len = 6'h08;
	logic [31:0] m_tx = 32'h0000_0000;
	logic [31:0] m_rx;
	logic        s_ss_n = 1'b1;
	logic        s_sck = 1'b0;
	logic        s_sdi = 1'b0;
	int          bad_count = 0;
	int          checks = 0;
	realtime     t_last = 0;
	realtime     half = 0;

	always #5 sys_clk = ~sys_clk;
	// half period of the last two clock edges
	always @(sck_o) begin
		if (t_last > 0)
			half = $realtime - t_last;
		t_last = $realtime;
	end

	spx_port u_spx_port (
		.sys_clk(sys_clk), .reset(reset), .sfr_addr(sfr_addr),
		.sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
		.sfr_rdata(sfr_rdata), .spi_irq(spi_irq),
		.sdi_i(s_ss_n ? sdi : s_sdi),
		.ss_n_i(s_ss_n), .sck_i(s_sck), .sck_o(sck_o), .sck_oe(sck_oe),
		.sdo_o(sdo_o), .sdo_oe(sdo_oe), .sel_n_o(sel_n_o),
		.sel_oe(sel_oe));
	spx_slave_model u_spx_slave_model (
		.sck(sck_o), .sel_n(sel_n_o[line]), .sdo(sdo_o), .sdi(sdi),
		.mode(m_mode), .len(m_len), .tx(m_tx), .rx(m_rx));

	// ==========================================================
	// access and compare
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge sys_clk);
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		@(negedge sys_clk);
		sfr_wr = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge sys_clk);
		sfr_addr = a;
		sfr_rd = 1'b1;
		@(negedge sys_clk);
		sfr_rd = 1'b0;
		d = sfr_rdata;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		rd(a, d);
		chk({24'h00_0000, d}, {24'h00_0000, e});
	endtask
	task automatic xfer(input int code, input int mode, input int ln,
		input int n, input logic [31:0] w);
		logic [31:0] msk;
		logic [31:0] got;
		logic [7:0]  b;
		int          k;
		msk = 32'hffff_ffff >> (32 - n);
		m_mode = mode[1:0];
		line = ln[1:0];
		m_len = n[5:0];
		m_tx = ~w ^ 32'h0f0f_0f0f;
		wr(SPX_ADDR_CTRL1, {code[2:0], ln[1:0], mode[0], mode[1], 1'b0});
		wr(SPX_ADDR_LEN, n[7:0] - 8'h01);
		// byte0 goes last, it commits the word
		for (k = 3; k >= 0; k--) begin
			if (k == 0)
				t_last = 0;
			wr(SPX_ADDR_DATA0 + k[7:0], w[8*k +: 8]);
		end
		b = 8'h00;
		for (k = 0; k < 400 && b[SPX_AV_BIT] !== 1'b1; k++)
			rd(SPX_ADDR_STATUS, b);
		chk({31'h0, b[SPX_AV_BIT]}, 32'h0000_0001);
		chk($rtoi(half), 10 << code);
		got = 32'h0000_0000;
		for (k = 3; k >= 0; k--) begin
			rd(SPX_ADDR_DATA0 + k[7:0], b);
			got[8*k +: 8] = b;
		end
		// input is synced, the two fastest rates may miss it
		if (code >= 2) begin
			chk(m_rx & msk, w & msk);
			chk(got & msk, m_tx & msk);
		end
	endtask

	// ==========================================================
	// scenarios
	task automatic t_reset();
		logic [7:0] d;
		rchk(SPX_ADDR_PIN_ROUTE, 8'h00);
		rchk(SPX_ADDR_CTRL1, 8'h00);
		rchk(SPX_ADDR_CTRL2, 8'h00);
		rd(SPX_ADDR_LEN, d);
		chk({27'h0, d[4:0]}, 32'h0000_0007);
		rchk(SPX_ADDR_STATUS, 8'h01);
		rchk(8'he8, 8'h00);
		$display("test reset done");
	endtask
	task automatic t_modes();
		int lens[4] = '{1, 8, 17, 32};
		wr(SPX_ADDR_PIN_ROUTE, 8'hff);
		for (int m = 0; m < 4; m++)
			xfer(2, m, 3 - m, lens[m], 32'ha5c3_9e71 + m);
		$display("test modes done");
	endtask
	task automatic t_div();
		for (int c = 0; c < 6; c++)
			xfer(c, 0, 0, 2, 32'h0000_0002);
		$display("test divider done");
	endtask
	task automatic t_hold();
		wr(SPX_ADDR_CTRL2, 8'h80);
		xfer(2, 1, 1, 8, 32'h0000_003c);
		chk({28'h0, sel_n_o}, 32'h0000_000d);
		wr(SPX_ADDR_CTRL2, 8'h00);
		repeat (3) @(negedge sys_clk);
		chk({28'h0, sel_n_o}, 32'h0000_000f);
		$display("test hold done");
	endtask
	task automatic t_status();
		logic [7:0] d;
		wr(SPX_ADDR_CTRL2, 8'h01);
		repeat (2) @(negedge sys_clk);
		chk({31'h0, spi_irq}, 32'h0000_0001);
		wr(SPX_ADDR_CTRL2, 8'h41);
		rchk(SPX_ADDR_CTRL2, 8'h01);
		rchk(SPX_ADDR_STATUS, 8'h00);
		chk({31'h0, spi_irq}, 32'h0000_0000);
		wr(SPX_ADDR_CTRL2, 8'h06);
		// second word waits in the buffer behind the first
		wr(SPX_ADDR_DATA0, 8'h5a);
		wr(SPX_ADDR_DATA0, 8'ha5);
		repeat (300) @(negedge sys_clk);
		chk({31'h0, spi_irq}, 32'h0000_0001);
		rchk(SPX_ADDR_STATUS, 8'h07);
		rchk(SPX_ADDR_STATUS, 8'h03);
		rd(SPX_ADDR_DATA0, d);
		rchk(SPX_ADDR_STATUS, 8'h01);
		wr(SPX_ADDR_CTRL2, 8'h00);
		$display("test status done");
	endtask
	task automatic t_slave();
		logic [3:0] w;
		w = 4'h9;
		wr(SPX_ADDR_PIN_ROUTE, 8'hf0);
		wr(SPX_ADDR_CTRL1, 8'h01);
		wr(SPX_ADDR_LEN, 8'h03);
		wr(SPX_ADDR_DATA0, {4'h0, w});
		s_ss_n = 1'b0;
		// mode 0: launch on rising, sample on falling
		for (int i = 3; i >= 0; i--) begin
			repeat (8) @(negedge sys_clk);
			s_sck = 1'b1;
			s_sdi = i[0];
			repeat (8) @(negedge sys_clk);
			chk({30'h0, sdo_oe, sdo_o}, {30'h0, 1'b1, w[i]});
			s_sck = 1'b0;
		end
		repeat (8) @(negedge sys_clk);
		s_ss_n = 1'b1;
		rchk(SPX_ADDR_DATA0, 8'h0a);
		wr(SPX_ADDR_CTRL1, 8'h00);
		$display("test slave done");
	endtask
	task automatic t_route();
		wr(SPX_ADDR_PIN_ROUTE, 8'h0a);
		repeat (3) @(negedge sys_clk);
		chk({26'h0, sck_oe, sdo_oe, sel_oe}, 32'h0000_0005);
		wr(SPX_ADDR_PIN_ROUTE, 8'h6f);
		repeat (3) @(negedge sys_clk);
		chk({26'h0, sck_oe, sdo_oe, sel_oe}, 32'h0000_003f);
		wr(SPX_ADDR_CTRL1, 8'h01);
		repeat (3) @(negedge sys_clk);
		chk({26'h0, sck_oe, sdo_oe, sel_oe}, 32'h0000_0000);
		wr(SPX_ADDR_CTRL1, 8'h00);
		$display("test route done");
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	initial begin
		repeat (20) @(negedge sys_clk);
		reset = 1'b0;
		t_reset();
		t_modes();
		t_div();
		t_hold();
		t_status();
		t_slave();
		t_route();
		finish_test();
	end
	// several times the expected run
	initial begin
		#100_000;
		bad_count++;
		finish_test();
	end
endmodule
